/* logic/config_store_map.vh */
// Register addresses, reset values and timing counts of the configuration store
`ifndef CONFIG_STORE_MAP_VH
`define CONFIG_STORE_MAP_VH
`define ADDR_ACCESS_CODE_LEVEL 16'h9DE9
`define ADDR_NV_COUNT_PART_A 16'h9E2B
`define ADDR_NV_COUNT_PART_B 16'h9E2C
`define ADDR_LEVEL_TABLE_BASE 16'hA000
`define ADDR_CFG_BASE 16'hA100
`define RST_ACCESS_LEVEL 2'h1
`define LEVEL_MAX 2'h3
`define NUM_CFG 16
`define CFG_IDX_W 4
`define LOCK_THRESHOLD 3'h3
`define STATS_PERIOD_MIN 60
`define CLK_HZ 50000000
`define STATS_PERIOD_CYCLES (`STATS_PERIOD_MIN * 60 * `CLK_HZ)
`define CODE_LEVEL2 16'h0002
`define CODE_LEVEL3 16'h0003
`define CODE_LEVEL1 16'h0001
`endif

/* logic/port_access_guard.v */
// Per-port access level, login and invalid-code lockout
`timescale 1ns/1ps
`default_nettype none
`include "config_store_map.vh"
module port_access_guard (
   input wire clk,
   input wire sys_rst,
   input wire ce,
   input wire code_wr,
   input wire [15:0] code,
   input wire [15:0] code_level2,
   input wire [15:0] code_level3,
   output reg [1:0] level,
   output reg locked
);
   reg [2:0] bad_count;
   reg valid;
   reg [1:0] new_level;
   always @* begin
      valid = 1'b1;
      new_level = `RST_ACCESS_LEVEL;
      if (code == code_level3)
         new_level = 2'h3;
      else if (code == code_level2)
         new_level = 2'h2;
      else if (code == `CODE_LEVEL1)
         new_level = 2'h1;
      else
         valid = 1'b0;
   end
   always @(posedge clk) begin
      if (sys_rst) begin
         level <= `RST_ACCESS_LEVEL;
         locked <= 1'b0;
         bad_count <= 3'h0;
      end else if (ce && code_wr && !locked) begin
         level <= new_level;
         if (valid) begin
            bad_count <= 3'h0;
         end else begin
            bad_count <= bad_count + 3'h1;
            if (bad_count + 3'h1 >= `LOCK_THRESHOLD)
               locked <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* logic/config_store_access_control.v */
// Configuration store with nonvolatile image, write counting and per-port access control
`timescale 1ns/1ps
`default_nettype none
`include "config_store_map.vh"
module config_store_access_control #(
   parameter [31:0] STATS_PERIOD = `STATS_PERIOD_CYCLES
) (
   input wire clk,
   input wire sys_rst,
   input wire ce,
   input wire req,
   input wire req_port,
   input wire req_write,
   input wire req_store,
   input wire [15:0] req_addr,
   input wire [15:0] req_wdata,
   input wire power_loss,
   input wire [15:0] stats_value,
   output reg resp_valid,
   output reg resp_ok,
   output reg [15:0] resp_rdata,
   output reg ready,
   output reg nv_busy,
   output reg [1:0] level_port0,
   output reg [1:0] level_port1,
   output reg locked_port0,
   output reg locked_port1
);
   localparam ST_LOAD = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam integer LAST_I = `NUM_CFG - 1;
   localparam [3:0] LAST = LAST_I[3:0];
   localparam [3:0] STATS_SLOT = LAST;

   // Nonvolatile image and working copies; the image has no reset so it outlives sys_rst
   reg [15:0] nv_mem [0:`NUM_CFG-1];
   reg [15:0] work [0:`NUM_CFG-1];
   reg [1:0] min_level [0:`NUM_CFG-1];
   reg [1:0] state;
   reg [3:0] load_idx;
   reg [31:0] nv_count;
   reg [31:0] stats_timer;
   reg [2:0] pl_sync;
   reg pl_seen;
   wire [1:0] level [0:1];
   wire locked [0:1];
   wire [15:0] code_level2 = `CODE_LEVEL2;
   wire [15:0] code_level3 = `CODE_LEVEL3;

   wire [1:0] req_level = req_port ? level[1] : level[0];
   wire is_access = req_addr == `ADDR_ACCESS_CODE_LEVEL;
   wire in_cfg = req_addr[15:`CFG_IDX_W] == `ADDR_CFG_BASE >> `CFG_IDX_W;
   wire in_lvl = req_addr[15:`CFG_IDX_W] == `ADDR_LEVEL_TABLE_BASE >> `CFG_IDX_W;
   wire [3:0] idx = req_addr[3:0];
   wire run = state == ST_RUN;
   wire allowed = req_level >= min_level[idx];
   wire cfg_wr = run && req && req_write && in_cfg && allowed;
   wire pl_level = pl_sync[2] & pl_sync[1];
   wire hour_tick = stats_timer == STATS_PERIOD - 32'h1;
   wire stats_save = run && (hour_tick || (pl_level && !pl_seen));
   wire store_wr = cfg_wr && req_store && !stats_save;
   // A refused store must leave the working copy alone too, or a retry would look redundant
   wire cfg_take = cfg_wr && !(req_store && stats_save);
   wire write_req = run && req && req_write;
   wire read_req = run && req && !req_write;
   reg [15:0] next_rdata;
   reg next_read_ok;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_port
         port_access_guard u_guard (
            .clk(clk),
            .sys_rst(sys_rst),
            .ce(ce),
            .code_wr(run && req && req_write && is_access && req_port == g),
            .code(req_wdata),
            .code_level2(code_level2),
            .code_level3(code_level3),
            .level(level[g]),
            .locked(locked[g])
         );
      end
   endgenerate

   // Read mux: reads are never gated by the access level of the port
   always @* begin
      next_rdata = 16'h0000;
      next_read_ok = 1'b1;
      if (is_access)
         next_rdata = {14'h0000, req_level};
      else if (req_addr == `ADDR_NV_COUNT_PART_A)
         next_rdata = nv_count[31:16];
      else if (req_addr == `ADDR_NV_COUNT_PART_B)
         next_rdata = nv_count[15:0];
      else if (in_cfg)
         next_rdata = work[idx];
      else if (in_lvl)
         next_rdata = {14'h0000, min_level[idx]};
      else
         next_read_ok = 1'b0;
   end

   // Answer path: exactly one registered reply per taken request
   always @(posedge clk) begin
      if (sys_rst) begin
         resp_valid <= 1'b0;
         resp_ok <= 1'b0;
         resp_rdata <= 16'h0000;
      end else if (ce) begin
         resp_valid <= run && req;
         if (write_req) begin
            resp_rdata <= 16'h0000;
            // Store colliding with a statistics save is refused so the tool retries
            resp_ok <= is_access || cfg_take;
         end else if (read_req) begin
            resp_rdata <= next_rdata;
            resp_ok <= next_read_ok;
         end
      end
   end

   // Power-loss pin is asynchronous; a level counts once the two late stages agree
   always @(posedge clk) begin
      if (sys_rst) begin
         pl_sync <= 3'h0;
         pl_seen <= 1'b0;
         stats_timer <= 32'h0;
      end else if (ce) begin
         pl_sync <= {pl_sync[1:0], power_loss};
         if (run) begin
            stats_timer <= hour_tick ? 32'h0 : stats_timer + 32'h1;
            // One power-loss save per run: the supply is going away anyway
            if (pl_level)
               pl_seen <= 1'b1;
         end
      end
   end

   // Guard mirrors lag one cycle so every top output leaves a flip-flop
   always @(posedge clk) begin
      if (sys_rst) begin
         level_port0 <= `RST_ACCESS_LEVEL;
         level_port1 <= `RST_ACCESS_LEVEL;
         locked_port0 <= 1'b0;
         locked_port1 <= 1'b0;
      end else if (ce) begin
         level_port0 <= level[0];
         level_port1 <= level[1];
         locked_port0 <= locked[0];
         locked_port1 <= locked[1];
      end
   end

   integer i;
   always @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_LOAD;
         load_idx <= 4'h0;
         nv_count <= 32'h0;
         ready <= 1'b0;
         nv_busy <= 1'b0;
         // Level table: first quarter start-up, then level 2 groups, rest commissioning
         for (i = 0; i < `NUM_CFG; i = i + 1)
            min_level[i] <= (i < 4) ? 2'h1 : (i < 8) ? 2'h2 : `LEVEL_MAX;
      end else if (ce) begin
         nv_busy <= 1'b0;
         case (state)
            ST_LOAD: begin
               work[load_idx] <= nv_mem[load_idx];
               load_idx <= load_idx + 4'h1;
               if (load_idx == LAST) begin
                  state <= ST_RUN;
                  ready <= 1'b1;
               end
            end
            ST_RUN: begin
               if (stats_save) begin
                  nv_mem[STATS_SLOT] <= stats_value;
                  nv_count <= nv_count + 32'h1;
                  nv_busy <= 1'b1;
               end else if (store_wr) begin
                  nv_mem[idx] <= req_wdata;
                  nv_count <= nv_count + 32'h1;
                  nv_busy <= 1'b1;
               end
               if (cfg_take)
                  work[idx] <= req_wdata;
            end
            default: state <= ST_LOAD;
         endcase
      end
   end
endmodule
`default_nettype wire

/* bench/cfg_store_props.sv */
// Port assertions for the configuration store
`timescale 1ns/1ps
`default_nettype none
module cfg_store_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic req,
   input wire logic req_port,
   input wire logic req_write,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic resp_valid,
   input wire logic resp_ok,
   input wire logic [15:0] resp_rdata,
   input wire logic ready,
   input wire logic [1:0] level_port0,
   input wire logic locked_port0
);
   wire tk = req && ready;
   wire code0 = tk && req_write && !req_port && req_addr == 16'h9DE9;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_answer_next: assert property (tk |=> resp_valid) else $error("no answer");
   a_no_stray: assert property (resp_valid |-> $past(tk)) else $error("stray answer");
   a_level_read: assert property (tk && !req_write && !req_port && req_addr == 16'h9DE9 |=>
      resp_ok && resp_rdata == {14'h0, $past(level_port0)}) else $error("level read");
   a_code_taken: assert property (code0 |=> resp_ok) else $error("code refused");
   a_bad_code: assert property (code0 && (req_wdata == 16'h0 || req_wdata > 16'h3) |=> ##1
      level_port0 == 2'h1) else $error("bad code level");
   a_lock_level: assert property (locked_port0 |-> level_port0 == 2'h1) else $error("lock");
   a_lock_holds: assert property (locked_port0 |=> locked_port0) else $error("unlock");
   a_port_apart: assert property (tk && req_port |=> ##1 $stable(level_port0))
      else $error("port crosstalk");
   a_count_ro: assert property (tk && req_write && req_addr == 16'h9E2B |=> !resp_ok)
      else $error("count written");
   a_ready_stays: assert property (ready |=> ready) else $error("ready lost");
   cover property (code0 ##1 resp_ok);
   cover property (locked_port0);
   cover property (tk && req_port && req_write);
endmodule
bind config_store_access_control cfg_store_props chk (.clk(clk), .sys_rst(sys_rst), .req(req),
   .req_port(req_port), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
   .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_rdata(resp_rdata), .ready(ready),
   .level_port0(level_port0), .locked_port0(locked_port0));
`default_nettype wire

/* bench/modbus_requester.sv */
// Far-side requester: controller or service tool issuing register transfers
`timescale 1ns/1ps
`default_nettype none
module modbus_requester (
   input wire logic clk,
   input wire logic resp_valid,
   input wire logic resp_ok,
   input wire logic [15:0] resp_rdata,
   output logic req,
   output logic req_port,
   output logic req_write,
   output logic req_store,
   output logic [15:0] req_addr,
   output logic [15:0] req_wdata
);
   initial begin
      {req, req_port, req_write, req_store, req_addr, req_wdata} = '0;
   end
   task automatic xfer(input logic p, w, s, input logic [15:0] a, d,
                       output logic ok, output logic [15:0] rd);
      int n;
      @(negedge clk);
      req = 1;
      {req_port, req_write, req_store, req_addr, req_wdata} = {p, w, s, a, d};
      @(negedge clk);
      req = 0;
      // Released address and data fields show junk so a stale value is never trusted
      req_addr = ~a;
      req_wdata = ~d;
      n = 0;
      while (resp_valid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      ok = resp_ok;
      rd = resp_rdata;
   endtask
endmodule
`default_nettype wire

/* bench/config_store_access_control_bench.sv */
// Self-checking bench for the configuration store
`timescale 1ns/1ps
`default_nettype none
module config_store_access_control_bench;
   logic clk = 0, sys_rst = 1, power_loss = 0, ok;
   logic [15:0] rd;
   logic [31:0] c0, c1;
   wire req, rp, rw, rs, rv, ro, rdy, nvb, lk0, lk1;
   wire [15:0] ra, rwd, rrd;
   wire [1:0] lv0, lv1;
   int errors = 0, cmp_count = 0;
   initial forever #10 clk = ~clk;
   config_store_access_control #(.STATS_PERIOD(32'd50000)) uut (.clk(clk), .sys_rst(sys_rst),
      .ce(1'b1), .req(req), .req_port(rp), .req_write(rw), .req_store(rs), .req_addr(ra),
      .req_wdata(rwd), .power_loss(power_loss), .stats_value(16'h1234), .resp_valid(rv),
      .resp_ok(ro), .resp_rdata(rrd), .ready(rdy), .nv_busy(nvb), .level_port0(lv0),
      .level_port1(lv1), .locked_port0(lk0), .locked_port1(lk1));
   modbus_requester host (.clk(clk), .resp_valid(rv), .resp_ok(ro), .resp_rdata(rrd), .req(req),
      .req_port(rp), .req_write(rw), .req_store(rs), .req_addr(ra), .req_wdata(rwd));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic p, s, input logic [15:0] a, d);
      host.xfer(p, 1'b1, s, a, d, ok, rd);
   endtask
   task rdr(input logic p, input logic [15:0] a);
      host.xfer(p, 1'b0, 1'b0, a, 16'h0, ok, rd);
   endtask
   task get_cnt(output logic [31:0] v);
      rdr(0, 16'h9E2B);
      v[31:16] = rd;
      rdr(0, 16'h9E2C);
      v[15:0] = rd;
   endtask
   task power_up;
      sys_rst = 1;
      repeat (10) @(negedge clk);
      sys_rst = 0;
      for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(negedge clk);
      chk(rdy, 1);
   endtask
   task t_levels;
      rdr(0, 16'h9DE9);
      chk(rd, 1);
      for (int c = 1; c <= 3; c++) begin
         wr(0, 0, 16'h9DE9, c[15:0]);
         rdr(0, 16'h9DE9);
         chk(rd, c);
      end
      rdr(1, 16'h9DE9);
      chk(rd, 1);
   endtask
   task t_access;
      wr(0, 0, 16'h9DE9, 16'h1);
      wr(0, 0, 16'hA104, 16'h11);
      chk(ok, 0);
      rdr(0, 16'hA104);
      chk(ok, 1);
      wr(0, 0, 16'hA100, 16'h22);
      chk(ok, 1);
      wr(0, 0, 16'h9DE9, 16'h2);
      wr(0, 0, 16'hA104, 16'h33);
      chk(ok, 1);
      wr(0, 0, 16'hA108, 16'h44);
      chk(ok, 0);
      wr(0, 0, 16'h9DE9, 16'h3);
      wr(0, 0, 16'hA108, 16'h55);
      chk(ok, 1);
   endtask
   task t_lockout;
      wr(1, 0, 16'h9DE9, 16'h3);
      wr(1, 0, 16'h9DE9, 16'h7777);
      @(negedge clk);
      chk(lv1, 1);
      repeat (2) wr(1, 0, 16'h9DE9, 16'h7777);
      wr(1, 0, 16'h9DE9, 16'h3);
      @(negedge clk);
      chk(lk1, 1);
      chk(lv1, 1);
      chk(lv0, 3);
      repeat (3) wr(0, 0, 16'h9DE9, 16'h7777);
      @(negedge clk);
      chk(lk0, 1);
      chk(lv0, 1);
   endtask
   task t_power_loss;
      get_cnt(c0);
      wr(0, 0, 16'h9E2B, 16'h0);
      chk(ok, 0);
      power_loss = 1;
      for (int i = 0; i < 20 && nvb !== 1'b1; i++) @(negedge clk);
      chk(nvb, 1);
      power_loss = 0;
      get_cnt(c1);
      chk(c1 - c0, 1);
   endtask
   task t_persist;
      get_cnt(c0);
      wr(0, 1, 16'hA101, 16'h5A5A);
      chk(ok, 1);
      get_cnt(c1);
      chk(c1 - c0, 1);
      power_up;
      chk(lk0, 0);
      rdr(0, 16'hA101);
      chk(rd, 16'h5A5A);
      get_cnt(c0);
      wr(0, 0, 16'hA101, 16'hC3C3);
      get_cnt(c1);
      chk(c1 - c0, 0);
      rdr(0, 16'hA101);
      chk(rd, 16'hC3C3);
      power_up;
      rdr(0, 16'hA101);
      chk(rd, 16'h5A5A);
      chk(lk1, 0);
   endtask
   task test_done;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      power_up;
      t_levels;
      t_access;
      t_lockout;
      t_power_loss;
      t_persist;
      test_done;
   end
   initial begin
      #100us;
      errors++;
      test_done;
   end
endmodule
`default_nettype wire
